// *** src/swid_host_pkg.sv ***
// Constants and types for the single-wire identification memory host
// Notes on behaviour
// R1 - Node selection must precede any memory command
// R2 - After selection, one of two memory commands
// R3 - All bits travel least significant first
// R4 - Identifier: family, 48-bit serial, CRC-8
// R5 - Check polynomial is x8 + x5 + x4 + 1
// R6 - Check starts at zero, family code first
// R7 - Shifting received CRC in leaves zero
// R8 - Seven 128-bit pages, admin bytes, identifier
// R9 - Pages are delivered open for writing
// R10 - Write-protected pages keep their contents
// R11 - AND-only pages store old AND new
// R12 - Segment programs within 16 ms; host waits
// R13 - Programming starts after commit byte's last slot
// R14 - Host waits full reset high interval
// R15 - Power-up presence ends within 2/20 ms
// R16 - Identifier serves as multidrop address
// R17 - Identifier region is never master-writable
// R18 - Admin region holds protection and factory bytes
// R19 - Page code 0h open, Ah AND-only
// R20 - Non-zero copy lock freezes page modes
// R21 - Line left idle while programming, then reset
package swid_host_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_LOW_NS = 48000;
  localparam int T_RST_HIGH_NS = 48000;
  localparam int T_PRES_SAMPLE_NS = 8000;
  localparam int T_WR0_LOW_NS = 8000;
  localparam int T_WR1_LOW_NS = 250;
  localparam int T_RD_LOW_NS = 250;
  localparam int T_RD_SAMPLE_NS = 2000;
  localparam int T_SLOT_NS = 13000;
  localparam int T_REC_NS = 5000;
  localparam int SEGMENT_PROGRAM_TIME_MS = 16;
  // Least times round up, the latest read sample point rounds down
  localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HIGH_CYC = (T_RST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRES_SAMPLE_CYC = (T_PRES_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR0_LOW_CYC = (T_WR0_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR1_LOW_CYC = (T_WR1_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LOW_CYC = (T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_SAMPLE_CYC = T_RD_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int SLOT_CYC = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC =
    (SEGMENT_PROGRAM_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CNT_W = 16;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY_LSB = 8'h8C;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ONE_BIT = 4'h1;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CRC = 8'h10;
  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_SEL_BIT = 3;
  localparam int CTRL_MEM_BIT = 4;
  localparam int CTRL_COMMIT_BIT = 5;
  localparam int CTRL_CRCCLR_BIT = 6;
  // Status fields
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_PRES_BIT = 1;
  localparam int STS_SELECTED_BIT = 2;
  localparam int STS_CRCZERO_BIT = 3;
  localparam int STS_ERRSEQ_BIT = 4;
  localparam int STS_ERRBUSY_BIT = 5;
  localparam int STS_PROG_BIT = 6;
  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
  typedef enum logic [2:0] {
    OP_NONE, OP_RESET, OP_WBYTE, OP_RBYTE, OP_WBIT, OP_RBIT
  } op_t;
  typedef enum logic [1:0] {SLOT_RESET, SLOT_WRITE, SLOT_READ} slot_kind_t;
endpackage

// *** src/swid_slot_if.sv ***
// Request and answer signals between controller and slot engine
`timescale 1ns/1ps
interface swid_slot_if;
  import swid_host_pkg::*;
  logic start;
  slot_kind_t kind;
  logic wbit;
  logic done;
  logic rbit;
  modport ctrl(output start, output kind, output wbit, input done, input rbit);
  modport engine(input start, input kind, input wbit, output done, output rbit);
endinterface

// *** src/swid_slot_engine.sv ***
// Timing engine for reset, write and read slots on the open-drain line
`timescale 1ns/1ps
module swid_slot_engine
  import swid_host_pkg::*;
#(
  parameter int RstLowCyc = RST_LOW_CYC,
  parameter int RstHighCyc = RST_HIGH_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Controller side
  swid_slot_if.engine slot,
  // Line
  input wire logic lineIn,
  output logic lineOeN
);
  typedef enum logic {S_IDLE, S_RUN} eng_state_t;
  localparam logic [SLOT_CNT_W-1:0] RstLow = SLOT_CNT_W'(RstLowCyc);
  localparam logic [SLOT_CNT_W-1:0] RstHigh = SLOT_CNT_W'(RstHighCyc);
  localparam logic [SLOT_CNT_W-1:0] PresAt = SLOT_CNT_W'(RstLowCyc + PRES_SAMPLE_CYC);
  localparam logic [SLOT_CNT_W-1:0] SlotEnd = SLOT_CNT_W'(SLOT_CYC + REC_CYC);
  eng_state_t state_q, state_d;
  logic [SLOT_CNT_W-1:0] cnt_q, cnt_d, lowLen, sampleAt, endAt;
  slot_kind_t kind_q, kind_d;
  logic wbit_q, wbit_d, rbit_q, rbit_d, done_q, done_d, oeN_q, oeN_d;

  always_comb begin
    lowLen = SLOT_CNT_W'(RD_LOW_CYC);
    sampleAt = SLOT_CNT_W'(RD_SAMPLE_CYC);
    endAt = SlotEnd;
    unique case (kind_q)
      SLOT_RESET: begin
        lowLen = RstLow;
        sampleAt = PresAt;
        endAt = RstLow + RstHigh;
      end
      SLOT_WRITE: begin
        lowLen = wbit_q ? SLOT_CNT_W'(WR1_LOW_CYC) : SLOT_CNT_W'(WR0_LOW_CYC);
      end
      default: begin
        lowLen = SLOT_CNT_W'(RD_LOW_CYC);
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    wbit_d = wbit_q;
    rbit_d = rbit_q;
    done_d = 1'b0;
    oeN_d = 1'b1;
    unique case (state_q)
      S_IDLE: begin
        if (slot.start) begin
          state_d = S_RUN;
          cnt_d = '0;
          kind_d = slot.kind;
          wbit_d = slot.wbit;
          oeN_d = 1'b0;
        end
      end
      S_RUN: begin
        cnt_d = cnt_q + 1'b1;
        oeN_d = !(cnt_d < lowLen);
        if (cnt_q == sampleAt) begin
          rbit_d = lineIn;
        end
        // Reset slot ends only after the full high interval R14
        if (cnt_q == endAt - 1'b1) begin
          state_d = S_IDLE;
          done_d = 1'b1;
          oeN_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      kind_q <= SLOT_RESET;
      wbit_q <= 1'b1;
      rbit_q <= 1'b1;
      done_q <= 1'b0;
      oeN_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      wbit_q <= wbit_d;
      rbit_q <= rbit_d;
      done_q <= done_d;
      oeN_q <= oeN_d;
    end
  end

  assign lineOeN = oeN_q;
  assign slot.done = done_q;
  assign slot.rbit = rbit_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_low_len: assert property ( // R14
    (state_q == S_RUN && kind_q == SLOT_RESET && $rose(oeN_q)) |-> cnt_q == RstLow)
    else $error("reset low time wrong");
  a_reset_high_len: assert property ( // R14
    (done_q && kind_q == SLOT_RESET) |-> (cnt_q == RstLow + RstHigh) && oeN_q)
    else $error("reset slot ended before high interval");
endmodule

// *** src/swid_crc8.sv ***
// Serial check generator for identifier and data bits
`timescale 1ns/1ps
module swid_crc8
  import swid_host_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bit stream
  input wire logic clear,
  input wire logic shiftEn,
  input wire logic inBit,
  output logic [7:0] crc
);
  logic [7:0] crc_q, crc_d;
  logic fb;

  always_comb begin
    fb = crc_q[0] ^ inBit;
    crc_d = crc_q;
    if (clear) begin
      crc_d = CRC_INIT; // R6
    end else if (shiftEn) begin
      crc_d = (crc_q >> 1) ^ (fb ? CRC_POLY_LSB : 8'h00); // R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_crc_clear_zero: assert property (clear |=> crc_q == 8'h00) // R6
    else $error("check not cleared to zero");
  a_crc_poly_tap: assert property ( // R5
    (shiftEn && !clear && crc_q == 8'h00 && inBit) |=> crc_q == CRC_POLY_LSB)
    else $error("feedback taps wrong");
endmodule

// *** src/swid_host_ctrl.sv ***
// Host controller for the single-wire identification memory
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module swid_host_ctrl
  import swid_host_pkg::*;
#(
  parameter int RstLowCyc = RST_LOW_CYC,
  parameter int RstHighCyc = RST_HIGH_CYC,
  parameter int ProgCyc = PROG_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Open-drain line
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOeN
);
  localparam int ProgW = $clog2(ProgCyc + 1);
  typedef enum logic [1:0] {ST_IDLE, ST_BIT, ST_PROG} ctl_state_t;

  swid_slot_if slot();

  ctl_state_t state_q, state_d;
  op_t op_q, op_d, ctrlOp;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d, statusVec;
  logic [7:0] txData_q, txData_d, txHold_q, txHold_d, shift_q, shift_d;
  logic [7:0] rx_q, rx_d, crcVal;
  logic [3:0] bitsLeft_q, bitsLeft_d;
  logic [ProgW-1:0] progCnt_q, progCnt_d;
  logic sel_q, sel_d, mem_q, mem_d, commit_q, commit_d;
  logic selected_q, selected_d, presence_q, presence_d;
  logic errSeq_q, errSeq_d, errBusy_q, errBusy_d, start_q, start_d;
  logic wbReq, wbWr, go, isRead, isWrite, crcClear, crcShift, crcBit;

  swid_slot_engine #(
    .RstLowCyc(RstLowCyc),
    .RstHighCyc(RstHighCyc)
  ) u_slot (
    .core_clk(core_clk),
    .rst(rst),
    .slot(slot),
    .lineIn(lineIn),
    .lineOeN(lineOeN)
  );

  swid_crc8 u_crc (
    .core_clk(core_clk),
    .rst(rst),
    .clear(crcClear),
    .shiftEn(crcShift),
    .inBit(crcBit),
    .crc(crcVal)
  );

  // Writes land at the edge where the master sees ack
  function automatic logic hit(input logic [7:0] off, input logic wr, input logic [7:0] adr);
    return wr && (adr == off);
  endfunction

  assign wbReq = cyc_i && stb_i;
  assign wbWr = wbReq && we_i && ack_q && sel_i[0];
  assign ctrlOp = op_t'(dat_i[CTRL_OP_LSB +: CTRL_OP_W]);
  assign go = hit(REG_CTRL, wbWr, adr_i) && ctrlOp inside {OP_RESET, OP_WBYTE, OP_RBYTE,
    OP_WBIT, OP_RBIT};
  assign isRead = (op_q == OP_RBYTE) || (op_q == OP_RBIT);
  assign isWrite = (op_q == OP_WBYTE) || (op_q == OP_WBIT);
  assign crcClear = hit(REG_CTRL, wbWr, adr_i) && dat_i[CTRL_CRCCLR_BIT] && state_q == ST_IDLE;

  // Line is open-drain: only ever pulled low
  assign lineOut = 1'b0;
  assign slot.start = start_q;
  assign slot.wbit = shift_q[0];
  assign slot.kind = (op_q == OP_RESET) ? SLOT_RESET : (isRead ? SLOT_READ : SLOT_WRITE);

  always_comb begin
    statusVec = REG_RESET_VAL;
    statusVec[STS_BUSY_BIT] = state_q != ST_IDLE;
    statusVec[STS_PRES_BIT] = presence_q;
    statusVec[STS_SELECTED_BIT] = selected_q;
    statusVec[STS_CRCZERO_BIT] = crcVal == 8'h00; // R7
    statusVec[STS_ERRSEQ_BIT] = errSeq_q;
    statusVec[STS_ERRBUSY_BIT] = errBusy_q;
    statusVec[STS_PROG_BIT] = state_q == ST_PROG;
  end

  always_comb begin
    ack_d = wbReq && !ack_q;
    rdat_d = rdat_q;
    if (wbReq && !ack_q) begin
      unique case (adr_i)
        REG_CTRL: rdat_d = {24'h00_0000, 2'b00, commit_q, mem_q, sel_q, op_q};
        REG_TXDATA: rdat_d = {24'h00_0000, txData_q};
        REG_RXDATA: rdat_d = {24'h00_0000, rx_q};
        REG_STATUS: rdat_d = statusVec;
        REG_CRC: rdat_d = {24'h00_0000, crcVal};
        default: rdat_d = REG_RESET_VAL;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    txData_d = txData_q;
    txHold_d = txHold_q;
    shift_d = shift_q;
    rx_d = rx_q;
    bitsLeft_d = bitsLeft_q;
    progCnt_d = progCnt_q;
    sel_d = sel_q;
    mem_d = mem_q;
    commit_d = commit_q;
    selected_d = selected_q;
    presence_d = presence_q;
    errSeq_d = errSeq_q;
    errBusy_d = errBusy_q;
    start_d = 1'b0;
    crcShift = 1'b0;
    crcBit = 1'b0;
    if (hit(REG_TXDATA, wbWr, adr_i)) begin
      txData_d = dat_i[7:0];
    end
    // Software clears error flags; a new error in the same cycle wins
    if (hit(REG_STATUS, wbWr, adr_i) && dat_i[STS_ERRSEQ_BIT]) begin
      errSeq_d = 1'b0;
    end
    if (hit(REG_STATUS, wbWr, adr_i) && dat_i[STS_ERRBUSY_BIT]) begin
      errBusy_d = 1'b0;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (go) begin
          if (ctrlOp != OP_RESET && dat_i[CTRL_MEM_BIT] && !selected_q) begin
            errSeq_d = 1'b1; // R1
          end else begin
            op_d = ctrlOp;
            sel_d = dat_i[CTRL_SEL_BIT];
            mem_d = dat_i[CTRL_MEM_BIT];
            commit_d = dat_i[CTRL_COMMIT_BIT];
            shift_d = txData_q;
            txHold_d = txData_q;
            bitsLeft_d = (ctrlOp == OP_WBYTE || ctrlOp == OP_RBYTE) ? BYTE_BITS : ONE_BIT;
            start_d = 1'b1;
            state_d = ST_BIT;
            if (ctrlOp == OP_RESET) begin
              selected_d = 1'b0; // R1
            end
          end
        end
      end
      ST_BIT: begin
        if (go) begin
          errBusy_d = 1'b1;
        end
        if (slot.done) begin
          crcShift = op_q != OP_RESET;
          crcBit = isRead ? slot.rbit : shift_q[0];
          shift_d = {crcBit, shift_q[7:1]}; // R3
          bitsLeft_d = bitsLeft_q - 1'b1;
          if (op_q == OP_RESET) begin
            presence_d = !slot.rbit;
          end
          if (bitsLeft_q == ONE_BIT) begin
            state_d = ST_IDLE;
            if (op_q == OP_RBYTE) begin
              rx_d = {crcBit, shift_q[7:1]}; // R3
            end else if (op_q == OP_RBIT) begin
              rx_d = {7'h00, slot.rbit};
            end
            if (isWrite && sel_q) begin
              selected_d = 1'b1; // R2
            end
            if (isWrite && commit_q) begin
              state_d = ST_PROG; // R13
              progCnt_d = '0;
            end
          end else begin
            start_d = 1'b1;
          end
        end
      end
      ST_PROG: begin
        // Line stays released for the whole segment programming time
        if (go) begin
          errBusy_d = 1'b1;
        end
        progCnt_d = progCnt_q + 1'b1;
        if (progCnt_q == ProgW'(ProgCyc - 1)) begin
          state_d = ST_IDLE; // R12
          selected_d = 1'b0; // R21
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      ack_q <= 1'b0;
      rdat_q <= REG_RESET_VAL;
      txData_q <= 8'h00;
      txHold_q <= 8'h00;
      shift_q <= 8'h00;
      rx_q <= 8'h00;
      bitsLeft_q <= 4'h0;
      progCnt_q <= '0;
      sel_q <= 1'b0;
      mem_q <= 1'b0;
      commit_q <= 1'b0;
      selected_q <= 1'b0;
      presence_q <= 1'b0;
      errSeq_q <= 1'b0;
      errBusy_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      txData_q <= txData_d;
      txHold_q <= txHold_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      bitsLeft_q <= bitsLeft_d;
      progCnt_q <= progCnt_d;
      sel_q <= sel_d;
      mem_q <= mem_d;
      commit_q <= commit_d;
      selected_q <= selected_d;
      presence_q <= presence_d;
      errSeq_q <= errSeq_d;
      errBusy_q <= errBusy_d;
      start_q <= start_d;
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_goMemUnselected;
    state_q == ST_IDLE && go && ctrlOp != OP_RESET && dat_i[CTRL_MEM_BIT] && !selected_q;
  endsequence
  sequence s_lastWriteDone;
    state_q == ST_BIT && slot.done && bitsLeft_q == ONE_BIT && isWrite;
  endsequence
  a_mem_needs_select: assert property ( // R1
    s_goMemUnselected |=> errSeq_q && state_q == ST_IDLE && !slot.start)
    else $error("memory command issued without selection");
  a_select_opens_mem: assert property ((s_lastWriteDone ##0 sel_q) |=> selected_q) // R2
    else $error("selection not recorded");
  a_write_lsb_first: assert property ( // R3
    (slot.start && op_q == OP_WBYTE) |-> slot.wbit == txHold_q[3'(BYTE_BITS - bitsLeft_q)])
    else $error("write bit order wrong");
  a_commit_starts_prog: assert property ( // R13
    (s_lastWriteDone ##0 commit_q) |=> state_q == ST_PROG && progCnt_q == '0)
    else $error("programming wait not started");
  a_prog_full_wait: assert property ( // R12
    (state_q == ST_PROG && state_d == ST_IDLE) |-> progCnt_q == ProgW'(ProgCyc - 1))
    else $error("programming wait cut short");
  a_prog_line_idle: assert property ((state_q == ST_PROG) |-> lineOeN && !slot.start) // R21
    else $error("line used while programming");
  a_prog_needs_reset: assert property ( // R21
    (state_q == ST_PROG ##1 state_q == ST_IDLE) |-> !selected_q)
    else $error("selection kept after programming");
  a_wb_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
endmodule

// *** tb/swid_dev_model.sv ***
// Behavioural single-wire identification device on the far side of the line
`timescale 1ns/1ps
module swid_dev_model #(
  // Arbitrary family and serial values, not tied to any real product
  parameter logic [7:0] FamilyCode = 8'hA7,
  parameter logic [47:0] SerialNum = 48'h5A3C_96E1_0F72
) (
  // Clock and line
  input wire logic core_clk,
  input wire logic lineLvl,
  output logic devOeN,
  // First eight bits written by the host after each reset
  output logic [7:0] rxByte
);
  function automatic logic [7:0] idCrc(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction
  // Fixed for the whole run: no host write can reach it
  localparam logic [63:0] IdBits = {idCrc({SerialNum, FamilyCode}), SerialNum, FamilyCode};
  function automatic logic [15:0] storeSeg(input logic [3:0] mode, input logic [15:0] old,
      input logic [15:0] nw);
    if (mode == 4'h0) return nw;
    if (mode == 4'hA) return old & nw;
    return old;
  endfunction
  // Seven pages of eight 16-bit segments; page modes live in the admin bytes
  logic [15:0] userSeg [56];
  // Delivered with every page open and the copy lock clear
  logic [63:0] adminBytes = 64'h0000_0000_0000_0000;
  logic [15:0] segIn = 16'h0000;
  int segCnt = 0;
  int segNum = 0;
  int lowCnt = 0;
  // Power-up presence runs at once and is over long before 2 ms
  int presT = 1;
  int slotCnt = 0;
  int nBits = 0;
  int bitIdx = 0;
  logic prevLvl = 1'b1;
  logic inSlot = 1'b0;
  initial begin
    devOeN = 1'b1;
    rxByte = 8'h00;
    foreach (userSeg[i]) userSeg[i] = 16'h0000;
  end
  always @(posedge core_clk) begin
    prevLvl <= lineLvl;
    lowCnt <= (lineLvl === 1'b0) ? lowCnt + 1 : 0;
    if (prevLvl === 1'b0 && lineLvl === 1'b1 && lowCnt >= 900) begin
      presT <= 1;
      nBits <= 0;
      bitIdx <= 0;
      inSlot <= 1'b0;
    end else if (presT > 0) begin
      // Presence sits over the host's sample point and ends before its slot does
      presT <= (presT == 900) ? 0 : presT + 1;
      devOeN <= !(presT >= 20 && presT < 900);
    end else if (prevLvl === 1'b1 && lineLvl === 1'b0 && !inSlot) begin
      inSlot <= 1'b1;
      slotCnt <= 0;
      // Answers only after a full command byte, with its own identifier
      if (nBits >= 8 && !IdBits[bitIdx]) begin
        devOeN <= 1'b0;
      end
    end else if (inSlot) begin
      slotCnt <= slotCnt + 1;
      if (slotCnt == 300) begin
        inSlot <= 1'b0;
        devOeN <= 1'b1;
        if (nBits < 8) begin
          rxByte <= {lineLvl, rxByte[7:1]};
          nBits <= nBits + 1;
        end else begin
          bitIdx <= (bitIdx + 1) % 64;
          segIn <= {lineLvl, segIn[15:1]};
          segCnt <= (segCnt + 1) % 16;
          if (segCnt == 15) begin
            userSeg[segNum] <= storeSeg(adminBytes[4 * (segNum / 8) +: 4], userSeg[segNum],
              {lineLvl, segIn[15:1]});
            segNum <= (segNum + 1) % 56;
          end
        end
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the identification memory host
`timescale 1ns/1ps
module testbench;
  import swid_host_pkg::*;
  localparam logic [7:0] FamilyCode = 8'hA7; // Arbitrary value
  localparam logic [47:0] SerialNum = 48'h5A3C_96E1_0F72; // Arbitrary value
  localparam int TimeoutCyc = 100000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cycI = 1'b0;
  logic stbI = 1'b0;
  logic weI = 1'b0;
  logic [7:0] adrI = 8'h00;
  logic [31:0] datI = 32'h0000_0000;
  logic [3:0] selI = 4'h0;
  logic [31:0] datO;
  logic ackO;
  logic lineOeN;
  logic devOeN;
  logic [7:0] rxByte;
  wire lineLvl;
  int errCount = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [7:0] crcExp;
  logic [7:0] idB;
  logic [7:0] adrList [5] = '{REG_CTRL, REG_TXDATA, REG_RXDATA, REG_CRC, 8'h14};
  // Open-drain line: low while either side pulls, pull-up level otherwise
  assign lineLvl = lineOeN & devOeN;
  always #5 core_clk = ~core_clk;
  // Long reset low kept above a zero-bit's low time so the model can tell them apart
  swid_host_ctrl #(.RstLowCyc(1000), .RstHighCyc(1000), .ProgCyc(50)) dut (
    .core_clk(core_clk), .rst(rst), .cyc_i(cycI), .stb_i(stbI), .we_i(weI),
    .adr_i(adrI), .dat_i(datI), .sel_i(selI), .dat_o(datO), .ack_o(ackO),
    .lineIn(lineLvl), .lineOut(), .lineOeN(lineOeN));
  swid_dev_model #(.FamilyCode(FamilyCode), .SerialNum(SerialNum)) model (
    .core_clk(core_clk), .lineLvl(lineLvl), .devOeN(devOeN), .rxByte(rxByte));
  task automatic conclude();
    if (errCount == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= w;
    adrI <= a;
    datI <= d;
    selI <= 4'hF;
    // Only the bench timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (ackO !== 1'b1);
    q = datO;
    cycI <= 1'b0;
    stbI <= 1'b0;
    weI <= 1'b0;
    @(posedge core_clk);
    chk("ack drop", {31'h0, ackO}, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbAcc(1'b1, a, d, q);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    wbAcc(1'b0, a, 32'h0000_0000, rd);
    chk(nm, rd & m, exp);
  endtask
  // Polls status; a byte takes some 14,400 cycles, far inside the bound
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      wbAcc(1'b0, REG_STATUS, 32'h0000_0000, rd);
      n++;
    end while (rd[STS_BUSY_BIT] !== 1'b0 && n < 10000);
    chk("busy", {31'h0, rd[STS_BUSY_BIT]}, 32'h0000_0000);
  endtask
  function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic [31:0] b(input int k);
    return 32'h0000_0001 << k;
  endfunction
  function automatic logic [31:0] ctl(input op_t op, input logic [31:0] flags);
    return 32'(op) | flags;
  endfunction
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == TimeoutCyc) begin
      errCount++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdChk("status reset", REG_STATUS, 32'hFFFF_FFFF, b(STS_CRCZERO_BIT));
    // Reset values, then a write to the unmapped offset 14h and to the read-only CRC register
    foreach (adrList[i]) rdChk("reg reset", adrList[i], 32'hFFFF_FFFF, REG_RESET_VAL);
    wr(8'h14, 32'h0000_00FF);
    wr(REG_CRC, 32'h0000_00FF);
    rdChk("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("crc ro", REG_CRC, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(REG_CTRL, ctl(OP_WBYTE, b(CTRL_MEM_BIT)));
    rdChk("early mem op", REG_STATUS, b(STS_ERRSEQ_BIT) | b(STS_BUSY_BIT), b(STS_ERRSEQ_BIT));
    wr(REG_STATUS, b(STS_ERRSEQ_BIT));
    rdChk("errseq clear", REG_STATUS, b(STS_ERRSEQ_BIT), 32'h0000_0000);
    wr(REG_CTRL, ctl(OP_RESET, 32'h0000_0000));
    waitIdle();
    rdChk("presence", REG_STATUS, b(STS_PRES_BIT) | b(STS_SELECTED_BIT), b(STS_PRES_BIT));
    wr(REG_TXDATA, 32'h0000_00C6);
    wr(REG_CTRL, ctl(OP_WBYTE, b(CTRL_SEL_BIT)));
    waitIdle();
    chk("line byte", {24'h0, rxByte}, 32'h0000_00C6);
    rdChk("selected", REG_STATUS, b(STS_SELECTED_BIT), b(STS_SELECTED_BIT));
    wr(REG_CTRL, b(CTRL_CRCCLR_BIT));
    rdChk("crc clear", REG_CRC, 32'h0000_00FF, 32'h0000_0000);
    crcExp = 8'h00;
    // Three bytes keep the run short; the check byte written back closes the sum
    for (int i = 0; i < 3; i++) begin
      wr(REG_CTRL, ctl(OP_RBYTE, 32'h0000_0000));
      waitIdle();
      idB = 8'({SerialNum, FamilyCode} >> (8 * i));
      rdChk("id byte", REG_RXDATA, 32'h0000_00FF, {24'h0, idB});
      crcExp = crcByte(crcExp, idB);
    end
    rdChk("crc", REG_CRC, 32'h0000_00FF, {24'h0, crcExp});
    wr(REG_TXDATA, {24'h0, crcExp});
    wr(REG_CTRL, ctl(OP_WBYTE, b(CTRL_MEM_BIT) | b(CTRL_COMMIT_BIT)));
    // Catch the programming wait while it runs, not after busy has cleared
    do wbAcc(1'b0, REG_STATUS, 32'h0000_0000, rd);
    while (rd[STS_PROG_BIT] !== 1'b1 && rd[STS_BUSY_BIT] === 1'b1);
    chk("programming", rd & b(STS_PROG_BIT), b(STS_PROG_BIT));
    chk("page store", {16'h0, model.userSeg[0]}, {16'h0, SerialNum[7:0], FamilyCode});
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      chk("line idle", {31'h0, lineOeN}, 32'h0000_0001);
    end
    rdChk("prog end", REG_STATUS, b(STS_PROG_BIT) | b(STS_SELECTED_BIT), 32'h0000_0000);
    rdChk("ctrl back", REG_CTRL, 32'h0000_00FF, 32'h0000_0032);
    rdChk("crc zero", REG_CRC, 32'h0000_00FF, 32'h0000_0000);
    rdChk("crc flag", REG_STATUS, b(STS_CRCZERO_BIT), b(STS_CRCZERO_BIT));
    wr(REG_CTRL, ctl(OP_RESET, 32'h0000_0000));
    wr(REG_CTRL, ctl(OP_RESET, 32'h0000_0000));
    rdChk("errbusy", REG_STATUS, b(STS_ERRBUSY_BIT), b(STS_ERRBUSY_BIT));
    waitIdle();
    wr(REG_STATUS, b(STS_ERRBUSY_BIT));
    rdChk("errbusy clear", REG_STATUS, b(STS_ERRBUSY_BIT), 32'h0000_0000);
    wr(REG_TXDATA, 32'h0000_0000);
    wr(REG_CTRL, ctl(OP_WBIT, 32'h0000_0000));
    waitIdle();
    chk("bit out", {31'h0, rxByte[7]}, 32'h0000_0000);
    // Device stays silent before a command, so the pull-up level comes back
    wr(REG_CTRL, ctl(OP_RBIT, 32'h0000_0000));
    waitIdle();
    rdChk("bit in", REG_RXDATA, 32'h0000_0001, 32'h0000_0001);
    conclude();
  end
endmodule
